// [verilog/ctrc_top.sv]
// Purpose: Charge termination, safety timers and automatic recharge control
// Assumes: Status pins are asynchronous; battery current code is quasi static
// Notes:   Registers over AXI4-Lite; switch_node_en low leaves the switch node floating
`timescale 1ns/100ps
`default_nettype none

module ctrc_top
  import ctrc_pkg::*;
#(
  parameter int unsigned SEC_CYC = ctrc_pkg::SEC_CYCLES  // Cycles per second tick
) (
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst_b,
  // AXI4-Lite write address
  input  wire logic [ctrc_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ctrc_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Power stage status
  input  wire logic                          input_above_battery,
  input  wire logic                          internal_rail_good,
  input  wire logic                          input_above_min_level,
  input  wire logic                          die_overheat,
  input  wire logic                          missing_freq_resistor,
  input  wire logic                          cell_strap_error,
  input  wire logic                          voltage_hold,
  input  wire logic                          thermistor_pause,
  input  wire logic                          below_recharge_level,
  input  wire logic                          below_restart_level,
  input  wire logic [15:0]                   battery_current,
  // Power stage control and alert
  output logic                               switch_node_en,
  output logic                               charging_halted,
  output logic                               smb_alert_b
);
  import ctrc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam int unsigned SYNC_W = 26;
  logic [SYNC_W-1:0] meta_reg;   // First stage, read only by second stage
  logic [SYNC_W-1:0] sync_reg;   // Second stage
  logic              above_bat;  // Synchronised status
  logic              rail_ok;
  logic              min_ok;
  logic              overheat;
  logic              no_res;
  logic              strap_err;
  logic              hold_phase;
  logic              pause;
  logic              recharge;
  logic              restart;
  logic [15:0]       ibat;

  // Two flops on every pin input
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= {battery_current, below_restart_level, below_recharge_level,
                   thermistor_pause, voltage_hold, cell_strap_error,
                   missing_freq_resistor, die_overheat, input_above_min_level,
                   internal_rail_good, input_above_battery};
      sync_reg <= meta_reg;
    end
  end

  assign {ibat, restart, recharge, pause, hold_phase, strap_err, no_res,
          overheat, min_ok, rail_ok, above_bat} = sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Timebase prescaler
  logic [31:0] sec_cnt_reg;   // Cycles within the second
  logic [5:0]  min_cnt_reg;   // Seconds within the minute
  logic        sec_tick_reg;  // One cycle per second
  logic        min_tick_reg;  // One cycle per minute

  // Free running second and minute enables
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sec_cnt_reg  <= '0;
      min_cnt_reg  <= '0;
      sec_tick_reg <= 1'b0;
      min_tick_reg <= 1'b0;
    end else begin
      sec_tick_reg <= 1'b0;
      min_tick_reg <= 1'b0;
      if (sec_cnt_reg == 32'(SEC_CYC - 1)) begin
        sec_cnt_reg  <= '0;
        sec_tick_reg <= 1'b1;
        if (min_cnt_reg == MIN_SECONDS - 6'h01) begin
          min_cnt_reg  <= '0;
          min_tick_reg <= 1'b1;
        end else begin
          min_cnt_reg <= min_cnt_reg + 6'h01;
        end
      end else begin
        sec_cnt_reg <= sec_cnt_reg + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and charge state
  logic [CTRL_W-1:0] ctrl_reg;        // Control bits
  logic [15:0]       hold_limit_reg;  // Hold phase limit, seconds
  logic [15:0]       elap_limit_reg;  // Elapsed limit, minutes
  logic [15:0]       taper_th_reg;    // Taper threshold
  logic [15:0]       hold_tmr_reg;    // Time spent in voltage hold
  logic [15:0]       elap_tmr_reg;    // Minutes since cycle start
  logic              elap_flt_reg;    // Elapsed limit fault
  logic              hold_done_reg;   // Hold timer termination
  logic              taper_done_reg;  // Taper termination
  ctrc_state_t       state_reg;
  ctrc_state_t       state_next;
  logic              halt_any;        // Any suspend condition
  logic              elap_hit;        // Elapsed limit reached
  logic              hold_hit;        // Hold limit reached
  logic              taper_hit;       // Taper current reached
  logic              new_cycle;       // Entering a fresh charge cycle
  logic              normal_end;      // Hold or taper termination

  assign halt_any  = ctrl_reg[C_HALT] | ~above_bat | ~rail_ok | ~min_ok
                   | overheat | no_res | strap_err;
  assign elap_hit  = (elap_limit_reg != 16'h0000)
                   && (elap_tmr_reg >= elap_limit_reg);
  assign hold_hit  = hold_phase && (hold_tmr_reg >= hold_limit_reg);
  assign taper_hit = ctrl_reg[C_TAPER_EN] && hold_phase && (ibat <= taper_th_reg);
  assign new_cycle = (state_next == CTRC_CHG) && (state_reg != CTRC_CHG);
  assign normal_end = (state_reg == CTRC_CHG) && (state_next == CTRC_DONE);

  // Next charge state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CTRC_CHG: begin
        if (halt_any) begin
          state_next = CTRC_HALT;
        end else if (elap_hit) begin
          state_next = CTRC_FAULT;
        end else if (hold_hit || taper_hit) begin
          state_next = CTRC_DONE;
        end
      end
      CTRC_DONE: begin
        if (halt_any) begin
          state_next = CTRC_HALT;
        end else if (recharge) begin
          state_next = CTRC_CHG;
        end
      end
      CTRC_FAULT: begin
        if (halt_any) begin
          state_next = CTRC_HALT;
        end else if (restart) begin
          state_next = CTRC_CHG;
        end
      end
      CTRC_HALT: begin
        if (!halt_any) begin
          state_next = CTRC_CHG;
        end
      end
    endcase
  end

  // State and pin outputs; reset enters a new cycle once inputs settle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg       <= CTRC_HALT;
      switch_node_en  <= 1'b0;
      charging_halted <= 1'b0;
    end else begin
      state_reg       <= state_next;
      switch_node_en  <= (state_next == CTRC_CHG);
      charging_halted <= (state_next == CTRC_HALT);
    end
  end

  // Elapsed counter
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      elap_tmr_reg <= '0;
    end else if (new_cycle || normal_end) begin
      elap_tmr_reg <= '0;
    end else if ((state_reg == CTRC_CHG) && !pause && min_tick_reg
                 && (elap_limit_reg != 16'h0000) && (elap_tmr_reg != 16'hffff)) begin
      elap_tmr_reg <= elap_tmr_reg + 16'h0001;
    end
  end

  // Hold phase timer, kept for read back after termination
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_tmr_reg <= '0;
    end else if (new_cycle) begin
      hold_tmr_reg <= '0;
    end else if ((state_reg == CTRC_CHG) && hold_phase && !pause
                 && sec_tick_reg && (hold_tmr_reg != 16'hffff)) begin
      hold_tmr_reg <= hold_tmr_reg + 16'h0001;
    end
  end

  // Termination flags
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      elap_flt_reg   <= 1'b0;
      hold_done_reg  <= 1'b0;
      taper_done_reg <= 1'b0;
    end else begin
      if ((state_reg == CTRC_CHG) && (state_next == CTRC_FAULT)) begin
        elap_flt_reg <= 1'b1;
      end else if ((state_next == CTRC_HALT) || new_cycle) begin
        elap_flt_reg <= 1'b0;
      end
      if (normal_end) begin
        hold_done_reg  <= hold_hit;
        taper_done_reg <= taper_hit;
      end else if (new_cycle) begin
        hold_done_reg  <= 1'b0;
        taper_done_reg <= 1'b0;
      end
    end
  end

  // Alert line, active low
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      smb_alert_b <= 1'b1;
    end else begin
      smb_alert_b <= ~((ctrl_reg[C_AL_TAPER] & taper_done_reg)
                     | (ctrl_reg[C_AL_HOLD] & hold_done_reg)
                     | (ctrl_reg[C_AL_ELAP] & elap_flt_reg));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic [ADDR_W-1:0] aw_addr_reg;  // Held write address
  logic [31:0]       w_data_reg;   // Held write data
  logic [3:0]        w_strb_reg;   // Held strobes
  logic              wr_go;        // Address and data both held
  logic              wr_hit;       // Write address decodes
  logic [31:0]       rd_mux;       // Read data for araddr
  logic              rd_hit;       // Read address decodes

  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // Byte merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Write channels, taken in either order
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr_reg   <= '0;
      w_data_reg    <= '0;
      w_strb_reg    <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Write decode, read-only words accept and ignore
  always_comb begin
    unique case (aw_addr_reg)
      A_CTRL, A_HOLD_LIMIT, A_ELAP_LIMIT, A_TAPER_THRESH,
      A_STATUS, A_HOLD_TIMER, A_ELAP_TIMER: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Software writable registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg       <= CTRL_RST;
      hold_limit_reg <= HOLD_LIMIT_RST;
      elap_limit_reg <= ELAP_LIMIT_RST;
      taper_th_reg   <= TAPER_RST;
    end else if (wr_go) begin
      if ((aw_addr_reg == A_CTRL) && w_strb_reg[0]) begin
        ctrl_reg <= w_data_reg[CTRL_W-1:0];
      end
      if (aw_addr_reg == A_HOLD_LIMIT) begin
        hold_limit_reg <= merge16(hold_limit_reg, w_data_reg, w_strb_reg);
      end
      if (aw_addr_reg == A_ELAP_LIMIT) begin
        elap_limit_reg <= merge16(elap_limit_reg, w_data_reg, w_strb_reg);
      end
      if (aw_addr_reg == A_TAPER_THRESH) begin
        taper_th_reg <= merge16(taper_th_reg, w_data_reg, w_strb_reg);
      end
    end
  end

  // Read multiplexer
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      A_CTRL:         rd_mux = {27'h0, ctrl_reg};
      A_HOLD_LIMIT:   rd_mux = {16'h0, hold_limit_reg};
      A_ELAP_LIMIT:   rd_mux = {16'h0, elap_limit_reg};
      A_TAPER_THRESH: rd_mux = {16'h0, taper_th_reg};
      A_STATUS:       rd_mux = {26'h0, hold_phase, (state_reg == CTRC_HALT),
                                taper_done_reg, hold_done_reg, elap_flt_reg,
                                (state_reg == CTRC_CHG)};
      A_HOLD_TIMER:   rd_mux = {16'h0, hold_tmr_reg};
      A_ELAP_TIMER:   rd_mux = {16'h0, elap_tmr_reg};
      default:        rd_hit = 1'b0;
    endcase
  end

  // Read channel, answer one cycle after the address
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence stopped_s;
    !switch_node_en && (state_reg != CTRC_CHG);
  endsequence

  sequence fresh_s;
    (hold_tmr_reg == 16'h0000) && (elap_tmr_reg == 16'h0000) && switch_node_en;
  endsequence

  elap_count_a: assert property ((state_reg == CTRC_CHG) && (state_next == CTRC_CHG)
      && !pause && min_tick_reg && (elap_limit_reg != 16'h0000)
      && (elap_tmr_reg < elap_limit_reg) |=> elap_tmr_reg == $past(elap_tmr_reg) + 16'h0001)
    else $error("elapsed counter did not advance");

  hold_count_a: assert property ((state_reg == CTRC_CHG) && (state_next == CTRC_CHG)
      && hold_phase && !pause && sec_tick_reg
      |=> hold_tmr_reg == $past(hold_tmr_reg) + 16'h0001)
    else $error("hold timer did not advance");

  limit_stop_a: assert property ((state_reg == CTRC_CHG) && !halt_any && elap_hit
      |=> stopped_s ##0 elap_flt_reg)
    else $error("elapsed limit did not stop charging");

  hold_rst_a: assert property ($rose(rst_b) |-> (hold_limit_reg == 16'h3840)
      && (taper_th_reg == 16'h03e8))
    else $error("limit reset values wrong");

  elap_off_a: assert property ((elap_limit_reg == 16'h0000) && (state_reg == CTRC_CHG)
      && (state_next == CTRC_CHG) |=> $stable(elap_tmr_reg))
    else $error("elapsed counter ran with zero limit");

  fault_keep_a: assert property (elap_flt_reg && !restart && !halt_any
      |=> elap_flt_reg && !switch_node_en)
    else $error("elapsed fault dropped early");

  fault_clr_a: assert property (elap_flt_reg && halt_any |=> !elap_flt_reg)
    else $error("elapsed fault not cleared by halt");

  taper_end_a: assert property ((state_reg == CTRC_CHG) && !halt_any && !elap_hit
      && taper_hit |=> stopped_s ##0 taper_done_reg ##0 (elap_tmr_reg == 16'h0000))
    else $error("taper termination missed");

  pause_hold_a: assert property ((state_reg == CTRC_CHG) && pause
      && (state_next == CTRC_CHG) |=> $stable(elap_tmr_reg) && $stable(hold_tmr_reg))
    else $error("timer advanced during pause");

  recharge_a: assert property ((state_reg == CTRC_DONE) && !halt_any && recharge
      |=> fresh_s)
    else $error("recharge did not restart cycle");

  // Sampled reset keeps the release edge, still in reset inside the design, out of the check
  halt_flag_a: assert property (rst_b && halt_any |=> charging_halted && !switch_node_en)
    else $error("halt not reported");

  alert_a: assert property (ctrl_reg[C_AL_HOLD] && hold_done_reg
      |=> !smb_alert_b)
    else $error("hold alert not raised");

endmodule // ctrc_top

`default_nettype wire

// [verilog/ctrc_pkg.sv]
// Purpose: Shared constants for the charge termination and recharge control block
// Assumes: 200 MHz ref_clk, 32-bit AXI4-Lite register port
// Notes:   Register offsets are byte addresses, one aligned word each
`default_nettype none

package ctrc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timebase
  localparam int unsigned CLK_PERIOD_NS = 5;              // Clock period
  localparam int unsigned SEC_TIME_NS   = 1_000_000_000;  // One second
  localparam int unsigned SEC_CYCLES    = SEC_TIME_NS / CLK_PERIOD_NS;
  localparam logic [5:0]  MIN_SECONDS   = 6'h3c;          // Seconds per minute

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int unsigned ADDR_W          = 8;
  localparam logic [7:0]  A_CTRL          = 8'h00;  // Control bits
  localparam logic [7:0]  A_HOLD_LIMIT    = 8'h04;  // Hold phase limit, seconds
  localparam logic [7:0]  A_ELAP_LIMIT    = 8'h08;  // Elapsed limit, minutes
  localparam logic [7:0]  A_TAPER_THRESH  = 8'h0c;  // Taper current threshold
  localparam logic [7:0]  A_STATUS        = 8'h10;  // Status flags
  localparam logic [7:0]  A_HOLD_TIMER    = 8'h14;  // Hold phase timer
  localparam logic [7:0]  A_ELAP_TIMER    = 8'h18;  // Elapsed counter

  // Control fields
  localparam int unsigned CTRL_W        = 5;
  localparam int unsigned C_HALT        = 0;  // Charging halt request
  localparam int unsigned C_TAPER_EN    = 1;  // Taper termination enable
  localparam int unsigned C_AL_TAPER    = 2;  // Alert on taper termination
  localparam int unsigned C_AL_HOLD     = 3;  // Alert on hold timer termination
  localparam int unsigned C_AL_ELAP     = 4;  // Alert on elapsed limit fault

  // Status fields
  localparam int unsigned S_CHARGING    = 0;
  localparam int unsigned S_ELAP_FAULT  = 1;
  localparam int unsigned S_HOLD_DONE   = 2;
  localparam int unsigned S_TAPER_DONE  = 3;
  localparam int unsigned S_HALTED      = 4;
  localparam int unsigned S_HOLD_PHASE  = 5;

  // Reset values
  localparam logic [4:0]  CTRL_RST       = 5'h00;
  localparam logic [15:0] HOLD_LIMIT_RST = 16'h3840;  // 14400 s
  localparam logic [15:0] ELAP_LIMIT_RST = 16'h0000;  // Counter disabled
  localparam logic [15:0] FULL_RATE_CODE = 16'h2710;  // Full charge rate code
  localparam logic [15:0] TAPER_DIV      = 16'h000a;  // One tenth
  localparam logic [15:0] TAPER_RST      = FULL_RATE_CODE / TAPER_DIV;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Charge cycle states
  typedef enum logic [1:0] {
    CTRC_CHG,
    CTRC_DONE,
    CTRC_FAULT,
    CTRC_HALT
  } ctrc_state_t;

endpackage

`default_nettype wire

// [verification/ctrc_stage_model.sv]
// Purpose: Power stage and battery model for the termination bench
// Assumes: Battery level given in per mille of the charge target
// Notes:   Hold flag and current follow the switching stage; level comparators do not
`timescale 1ns/100ps
`default_nettype none
module ctrc_stage_model (
  // Clock and bench controls
  input  wire logic        ref_clk,
  input  wire logic        switch_node_en,
  input  wire logic [9:0]  vbat_pm,
  input  wire logic [15:0] ibat_set,
  // Battery comparators and current
  output logic             below_recharge_level = 1'b0,
  output logic             below_restart_level  = 1'b0,
  output logic             voltage_hold         = 1'b0,
  output logic [15:0]      battery_current      = 16'h0000
);
  // Hold regulation only at full voltage while switching; no current when off
  always_ff @(posedge ref_clk) begin
    below_recharge_level <= vbat_pm < 10'h3cf;
    below_restart_level  <= vbat_pm < 10'h15e;
    voltage_hold         <= switch_node_en & (vbat_pm >= 10'h3e8);
    battery_current      <= switch_node_en ? ibat_set : 16'h0000;
  end
endmodule // ctrc_stage_model
`default_nettype wire

// [verification/ctrc_top_test.sv]
// Purpose: Self-checking bench for ctrc_top
// Assumes: SEC_CYC of 10, so a minute is 600 cycles
// Notes:   Stage model drives battery comparators
`timescale 1ns/100ps
`default_nettype none
module ctrc_top_test;
  import ctrc_pkg::*;
  logic        ref_clk = 0, rst_b = 0, pause = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, sw_en, halted, alert_b, vh, rch, rsl;
  logic [1:0]  bresp, rresp, r;
  logic [5:0]  flt = 0;            // One-hot supply fault
  logic [9:0]  vbat = 10'h1f4;     // Battery level, per mille
  logic [15:0] ibat = 16'h07d0, icur;
  int          fails = 0, cmp_count = 0;
  ctrc_top #(.SEC_CYC(10)) DUT (.ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .input_above_battery(~flt[0]), .internal_rail_good(~flt[1]), .input_above_min_level(~flt[2]),
    .die_overheat(flt[3]), .missing_freq_resistor(flt[4]), .cell_strap_error(flt[5]),
    .voltage_hold(vh), .thermistor_pause(pause), .below_recharge_level(rch),
    .below_restart_level(rsl), .battery_current(icur), .switch_node_en(sw_en),
    .charging_halted(halted), .smb_alert_b(alert_b));
  ctrc_stage_model stage (.ref_clk(ref_clk), .switch_node_en(sw_en), .vbat_pm(vbat),
    .ibat_set(ibat), .below_recharge_level(rch), .below_restart_level(rsl),
    .voltage_hold(vh), .battery_current(icur));
  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial forever #2.5 ref_clk = ~ref_clk;
  initial begin
    #100000;
    fails++;
    conclude;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Write: release each channel when taken, answer in bresp
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    r = bresp;
  endtask
  task rd(input logic [7:0] a);
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge ref_clk);
    rready <= 0;
    d = rdata;
    r = rresp;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset;
    rd(A_HOLD_LIMIT); chk(d, 32'h3840);
    rd(A_ELAP_LIMIT); chk(d, 32'h0);
    rd(A_TAPER_THRESH); chk(d, 32'h3e8);
    rd(8'h40); chk(r, RESP_SLVERR);
    wr(8'h40, 32'h1); chk(r, RESP_SLVERR);
  endtask
  task t_hold;
    wr(A_CTRL, 32'h8); wr(A_HOLD_LIMIT, 32'h5); vbat <= 10'h3e8; cyc(100);
    rd(A_STATUS); chk(d[3:1], 3'h2);
    chk(sw_en, 1'b0);
    chk(alert_b, 1'b0);
    rd(A_HOLD_TIMER); chk(d, 32'h5);
    rd(A_ELAP_TIMER); chk(d, 32'h0);
    wr(A_HOLD_LIMIT, 32'h3840); vbat <= 10'h3c0; cyc(20);
    chk(sw_en, 1'b1);
    chk(alert_b, 1'b1);
    rd(A_HOLD_TIMER); chk(d, 32'h0);
    vbat <= 10'h1f4;
  endtask
  task t_elapsed;
    pause <= 1; wr(A_CTRL, 32'h10); wr(A_ELAP_LIMIT, 32'h1); cyc(700);
    rd(A_ELAP_TIMER); chk(d, 32'h0);
    for (int i = 0; i < 2; i++) begin
      pause <= 0; cyc(700);
      rd(A_STATUS); chk(d[1:0], 2'h2);
      chk({alert_b, sw_en}, 2'h0);
      rd(A_ELAP_TIMER); chk(d, 32'h1);
      if (i == 0) begin
        flt <= 6'h1; cyc(10);
        rd(A_STATUS); chk(d[4:1], 4'h8);
        chk(alert_b, 1'b1);
        flt <= 0;
      end else begin
        cyc(700); rd(A_STATUS); chk(d[1:0], 2'h2);
        wr(A_ELAP_LIMIT, 32'h0); vbat <= 10'h12c; cyc(20); vbat <= 10'h1f4;
        rd(A_STATUS); chk(d[1:0], 2'h1);
        rd(A_ELAP_TIMER); chk(d, 32'h0);
      end
    end
  endtask
  task t_halt;
    for (int i = 0; i < 7; i++) begin
      if (i < 6) flt <= 6'h1 << i;
      else wr(A_CTRL, 32'h1);
      cyc(10);
      chk({halted, sw_en}, 2'h2);
      flt <= 0;
      if (i == 6) wr(A_CTRL, 32'h0);
      cyc(10);
      chk({halted, sw_en}, 2'h1);
    end
  endtask
  task t_taper;
    ibat <= 16'h03e8; wr(A_ELAP_LIMIT, 32'hffff); cyc(610);
    wr(A_CTRL, 32'h6); vbat <= 10'h3e8; cyc(30);
    rd(A_STATUS); chk(d[3:2], 2'h2);
    chk({alert_b, sw_en}, 2'h0);
    rd(A_ELAP_TIMER); chk(d, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and verdict
  task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    cyc(4);
    rst_b <= 1;
    cyc(10);
    t_reset;
    t_hold;
    t_elapsed;
    t_halt;
    t_taper;
    conclude;
  end
endmodule // ctrc_top_test
`default_nettype wire
